// >>> lsc_pkg.sv
// Purpose: shared constants and types for the link sequence control ends
// Assumes: one bit clock, control octets exchanged as whole bytes
// Notes:   bit 1 of the control field is bit 0 of an octet here
`default_nettype none
package lsc_pkg;
   typedef logic [2:0] lsc_seq_t; // modulo 8 counters
   typedef enum logic [2:0] {
      LSC_F_I    = 3'b000,
      LSC_F_RR   = 3'b001,
      LSC_F_RNR  = 3'b010,
      LSC_F_REJ  = 3'b011,
      LSC_F_SARM = 3'b100,
      LSC_F_SABM = 3'b101,
      LSC_F_UA   = 3'b110,
      LSC_F_OTH  = 3'b111
   } lsc_kind_t;
   typedef enum logic [1:0] {
      LSC_M_DISC = 2'b00,
      LSC_M_ARM  = 2'b01,
      LSC_M_ABM  = 2'b10
   } lsc_mode_t;
   // supervisory function codes, bits 3..4 as a 2-bit value (bit 3 low)
   localparam logic [1:0] LSC_S_RR  = 2'h0;
   localparam logic [1:0] LSC_S_RNR = 2'h1;
   localparam logic [1:0] LSC_S_REJ = 2'h2;
   // unnumbered codes with the P/F bit (bit 5, index 4) cleared
   localparam logic [7:0] LSC_U_SARM = 8'h0F;
   localparam logic [7:0] LSC_U_SABM = 8'h2F;
   localparam logic [7:0] LSC_U_DISC = 8'h43;
   localparam logic [7:0] LSC_U_UA   = 8'h63;
   localparam logic [7:0] LSC_U_FRMR = 8'h87;
   localparam logic [7:0] LSC_U_MASK = 8'hEF;
   localparam int         LSC_PF_BIT = 4;
   localparam lsc_seq_t   LSC_SEQ_RST = 3'h0;
   localparam lsc_seq_t   LSC_K_DEF   = 3'h7;
   localparam logic [2:0] LSC_BIT_LAST = 3'h7;

   function automatic logic [7:0] lsc_enc(input lsc_kind_t k, input lsc_seq_t ns,
                                          input lsc_seq_t nr, input logic pf);
      logic [7:0] c;
      c = 8'h00;
      unique case (k)
         LSC_F_I:    c = {nr, pf, ns, 1'b0};
         LSC_F_RR:   c = {nr, pf, LSC_S_RR, 2'b01};
         LSC_F_RNR:  c = {nr, pf, LSC_S_RNR, 2'b01};
         LSC_F_REJ:  c = {nr, pf, LSC_S_REJ, 2'b01};
         LSC_F_SARM: c = LSC_U_SARM;
         LSC_F_SABM: c = LSC_U_SABM;
         LSC_F_UA:   c = LSC_U_UA;
         LSC_F_OTH:  c = LSC_U_DISC;
      endcase
      if (k >= LSC_F_SARM) begin
         c[LSC_PF_BIT] = pf;
      end
      return c;
   endfunction

   function automatic lsc_kind_t lsc_dec(input logic [7:0] c);
      lsc_kind_t k;
      k = LSC_F_OTH;
      if (!c[0]) begin
         k = LSC_F_I;
      end else if (!c[1]) begin
         unique case (c[3:2])
            LSC_S_RR:  k = LSC_F_RR;
            LSC_S_RNR: k = LSC_F_RNR;
            LSC_S_REJ: k = LSC_F_REJ;
            default:   k = LSC_F_OTH;
         endcase
      end else if ((c & LSC_U_MASK) == LSC_U_SARM) begin
         k = LSC_F_SARM;
      end else if ((c & LSC_U_MASK) == LSC_U_SABM) begin
         k = LSC_F_SABM;
      end else if ((c & LSC_U_MASK) == LSC_U_UA) begin
         k = LSC_F_UA;
      end
      return k;
   endfunction
endpackage
`default_nettype wire

// >>> lsc_link_if.sv
// Purpose: serial control-field link between two stations
// Assumes: one shared clock; each direction a bit plus frame strobe
// Notes:   a_* is sent by the device end, b_* by the peer end
`timescale 1ns/100ps
`default_nettype none
interface lsc_link_if;
   logic a_bit;   // device to peer data bit
   logic a_vld;   // device bit valid
   logic a_info;  // device frame has info field
   logic b_bit;
   logic b_vld;
   logic b_info;
   modport dev  (output a_bit, output a_vld, output a_info,
                 input b_bit, input b_vld, input b_info);
   modport peer (input a_bit, input a_vld, input a_info,
                 output b_bit, output b_vld, output b_info);
endinterface
`default_nettype wire

// >>> lsc_station.sv
// Purpose: one link station: sequencing, control field, serial bits
// Assumes: frames error free when delivered; FCS and flags live elsewhere
// Notes:   is_dce selects the DCE window and SARM supervisory limits
`timescale 1ns/100ps
`default_nettype none
module lsc_station #(
   parameter bit IS_DCE = 1'b1
) (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   input  wire logic               tx_bit_i,
   input  wire logic               tx_vld_i,
   input  wire logic               tx_info_i,
   output logic                    rx_bit_o,
   output logic                    rx_vld_o,
   output logic                    rx_info_o,
   input  wire lsc_pkg::lsc_seq_t  k_i,
   input  wire logic               busy_i,
   input  wire logic               cmd_i,
   input  wire logic               send_i,
   input  wire lsc_pkg::lsc_kind_t kind_i,
   input  wire logic               pf_i,
   output logic                    send_rdy_o,
   output logic                    rcv_vld_o,
   input  wire logic               rcv_rdy_i,
   output logic [7:0]              rcv_ctl_o,
   output lsc_pkg::lsc_seq_t       vs_o,
   output lsc_pkg::lsc_seq_t       vr_o,
   output lsc_pkg::lsc_seq_t       ack_o,
   output lsc_pkg::lsc_mode_t      mode_o,
   output logic                    peer_busy_o,
   output logic                    rej_o,
   output logic                    status_req_o
);
   typedef enum logic [1:0] {
      LSC_T_IDLE = 2'b00,
      LSC_T_SEND = 2'b01
   } lsc_tst_t;

   lsc_pkg::lsc_seq_t  vs_q, vs_d, vr_q, vr_d, ack_q, ack_d;
   lsc_pkg::lsc_mode_t mode_q, mode_d;
   logic               pbusy_q, pbusy_d, rej_q, rej_d, sreq_q, sreq_d, ua_q, ua_d;
   lsc_tst_t           tst_q, tst_d;
   logic [7:0]         tsh_q, tsh_d, rsh_q, rsh_d;
   logic [2:0]         tcnt_q, tcnt_d, rcnt_q, rcnt_d;
   logic               tinf_q, tinf_d, rinf_q, rinf_d;
   // two-entry receive buffer
   logic [7:0]         buf_q [2];
   logic [7:0]         buf_d [2];
   logic [1:0]         cnt_q, cnt_d;
   logic               wp_q, wp_d, rp_q, rp_d;
   logic               rx_done, outst_full, sup_ok, pick_ua;
   logic [7:0]         rx_ctl;
   lsc_pkg::lsc_kind_t rk, tk;
   lsc_pkg::lsc_seq_t  nr;

   assign rx_ctl  = {tx_bit_i, rsh_q[7:1]};
   assign rx_done = tx_vld_i && (rcnt_q == lsc_pkg::LSC_BIT_LAST);
   assign rk      = lsc_pkg::lsc_dec(rx_ctl);
   assign nr      = rx_ctl[7:5];
   // window full when vs runs k ahead of last acknowledgement
   assign outst_full = IS_DCE && (3'(vs_q - ack_q) >= k_i);
   // dce in response mode may not issue supervisory commands
   assign sup_ok  = !(IS_DCE && cmd_i && mode_q == lsc_pkg::LSC_M_ARM);
   assign pick_ua = ua_q;
   assign tk      = pick_ua ? lsc_pkg::LSC_F_UA : kind_i;
   assign send_rdy_o = (tst_q == LSC_T_IDLE) && !pick_ua && !(kind_i == lsc_pkg::LSC_F_I
                       && (outst_full || pbusy_q)) && !(kind_i inside {lsc_pkg::LSC_F_RR,
                       lsc_pkg::LSC_F_RNR, lsc_pkg::LSC_F_REJ} && !sup_ok);
   assign rcv_vld_o  = (cnt_q != 2'h0);
   assign rcv_ctl_o  = buf_q[rp_q];

   // sequencing state, updated on whole received or accepted frames
   always_comb begin
      vs_d = vs_q; vr_d = vr_q; ack_d = ack_q; mode_d = mode_q;
      pbusy_d = pbusy_q; rej_d = rej_q; sreq_d = 1'b0;
      // a pending UA leaves on the first idle cycle; a new set mode below wins
      ua_d = ua_q && (tst_q != LSC_T_IDLE);
      if (rx_done) begin
         unique case (rk)
            lsc_pkg::LSC_F_I: begin
               ack_d = nr;
               if (rx_ctl[3:1] == vr_q && !busy_i) begin
                  vr_d = 3'(vr_q + 3'h1);
                  rej_d = 1'b0;
               end
            end
            lsc_pkg::LSC_F_RR: begin
               ack_d = nr; pbusy_d = 1'b0;
            end
            lsc_pkg::LSC_F_RNR: begin
               ack_d = nr; pbusy_d = 1'b1;
            end
            lsc_pkg::LSC_F_REJ: begin
               ack_d = nr; vs_d = nr; pbusy_d = 1'b0;
            end
            lsc_pkg::LSC_F_SARM: begin
               mode_d = lsc_pkg::LSC_M_ARM; ua_d = 1'b1;
            end
            lsc_pkg::LSC_F_SABM: begin
               if (!rinf_q) begin
                  mode_d = lsc_pkg::LSC_M_ABM; ua_d = 1'b1;
                  vs_d = lsc_pkg::LSC_SEQ_RST; vr_d = lsc_pkg::LSC_SEQ_RST;
                  ack_d = lsc_pkg::LSC_SEQ_RST; pbusy_d = 1'b0;
                  rej_d = 1'b0;
               end
            end
            lsc_pkg::LSC_F_UA: pbusy_d = 1'b0;
            default: ;
         endcase
         // any supervisory frame with the P/F bit set, command or response, asks for our status
         if (rk inside {lsc_pkg::LSC_F_RR, lsc_pkg::LSC_F_RNR, lsc_pkg::LSC_F_REJ}
             && rx_ctl[lsc_pkg::LSC_PF_BIT]) begin
            sreq_d = 1'b1;
         end
      end
      // user request only; send_rdy_o already excludes a pending UA
      if (tst_q == LSC_T_IDLE && send_i && send_rdy_o) begin
         if (kind_i == lsc_pkg::LSC_F_I) begin
            vs_d = 3'(vs_d + 3'h1);
         end else if (kind_i == lsc_pkg::LSC_F_REJ) begin
            rej_d = 1'b1; // one exception at a time
         end
      end
   end

   // transmit shift: lsb first, bit 1 on the line first
   always_comb begin
      tst_d = tst_q; tsh_d = tsh_q; tcnt_d = tcnt_q; tinf_d = tinf_q;
      unique case (tst_q)
         LSC_T_IDLE: begin
            if (send_i && send_rdy_o || pick_ua) begin
               tsh_d  = lsc_pkg::lsc_enc(tk, vs_q, vr_q, pick_ua ? 1'b1 : pf_i);
               tinf_d = !pick_ua && kind_i == lsc_pkg::LSC_F_I;
               tcnt_d = 3'h0;
               tst_d  = LSC_T_SEND;
            end
         end
         LSC_T_SEND: begin
            tsh_d  = {1'b0, tsh_q[7:1]};
            tcnt_d = 3'(tcnt_q + 3'h1);
            if (tcnt_q == lsc_pkg::LSC_BIT_LAST) begin
               tst_d = LSC_T_IDLE;
            end
         end
         default: tst_d = LSC_T_IDLE;
      endcase
   end

   // receive shift and two-entry buffer; a full buffer drops the newly received octet
   always_comb begin
      rsh_d = rsh_q; rcnt_d = rcnt_q; rinf_d = rinf_q;
      buf_d = buf_q; cnt_d = cnt_q; wp_d = wp_q; rp_d = rp_q;
      if (tx_vld_i) begin
         rsh_d  = {tx_bit_i, rsh_q[7:1]};
         rcnt_d = 3'(rcnt_q + 3'h1);
         if (rcnt_q == 3'h0) begin
            rinf_d = tx_info_i;
         end
      end
      if (rcv_vld_o && rcv_rdy_i) begin
         rp_d = !rp_q;
         cnt_d = 2'(cnt_d - 2'h1);
      end
      if (rx_done && cnt_q != 2'h2) begin
         buf_d[wp_q] = rx_ctl;
         wp_d = !wp_q;
         cnt_d = 2'(cnt_d + 2'h1);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vs_q <= lsc_pkg::LSC_SEQ_RST; vr_q <= lsc_pkg::LSC_SEQ_RST;
         ack_q <= lsc_pkg::LSC_SEQ_RST; mode_q <= lsc_pkg::LSC_M_DISC;
         pbusy_q <= 1'b0; rej_q <= 1'b0; sreq_q <= 1'b0; ua_q <= 1'b0;
         tst_q <= LSC_T_IDLE; tsh_q <= 8'h00; tcnt_q <= 3'h0; tinf_q <= 1'b0;
         rsh_q <= 8'h00; rcnt_q <= 3'h0; rinf_q <= 1'b0;
         buf_q[0] <= 8'h00; buf_q[1] <= 8'h00;
         cnt_q <= 2'h0; wp_q <= 1'b0; rp_q <= 1'b0;
      end else begin
         vs_q <= vs_d; vr_q <= vr_d; ack_q <= ack_d; mode_q <= mode_d;
         pbusy_q <= pbusy_d; rej_q <= rej_d; sreq_q <= sreq_d; ua_q <= ua_d;
         tst_q <= tst_d; tsh_q <= tsh_d; tcnt_q <= tcnt_d; tinf_q <= tinf_d;
         rsh_q <= rsh_d; rcnt_q <= rcnt_d; rinf_q <= rinf_d;
         buf_q <= buf_d;
         cnt_q <= cnt_d; wp_q <= wp_d; rp_q <= rp_d;
      end
   end

   assign rx_bit_o     = tsh_q[0];
   assign rx_vld_o     = (tst_q == LSC_T_SEND);
   assign rx_info_o    = tinf_q && (tst_q == LSC_T_SEND); // info flag only inside a frame
   assign vs_o         = vs_q;
   assign vr_o         = vr_q;
   assign ack_o        = ack_q;
   assign mode_o       = mode_q;
   assign peer_busy_o  = pbusy_q;
   assign rej_o        = rej_q;
   assign status_req_o = sreq_q;
endmodule
`default_nettype wire

// >>> lsc_dev_end.sv
// Purpose: device (DCE) end of the link
// Assumes: station core shared with the peer end
// Notes:   window and SARM supervisory limits active here
`timescale 1ns/100ps
`default_nettype none
module lsc_dev_end (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   lsc_link_if.dev                 link,
   input  wire lsc_pkg::lsc_seq_t  k_i,
   input  wire logic               busy_i,
   input  wire logic               cmd_i,
   input  wire logic               send_i,
   input  wire lsc_pkg::lsc_kind_t kind_i,
   input  wire logic               pf_i,
   output logic                    send_rdy_o,
   output logic                    rcv_vld_o,
   input  wire logic               rcv_rdy_i,
   output logic [7:0]              rcv_ctl_o,
   output lsc_pkg::lsc_seq_t       vs_o,
   output lsc_pkg::lsc_seq_t       vr_o,
   output lsc_pkg::lsc_seq_t       ack_o,
   output lsc_pkg::lsc_mode_t      mode_o,
   output logic                    peer_busy_o,
   output logic                    rej_o,
   output logic                    status_req_o
);
   // dce core: k window enforced
   lsc_station #(.IS_DCE(1'b1)) u_st (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .tx_bit_i(link.b_bit), .tx_vld_i(link.b_vld), .tx_info_i(link.b_info),
      .rx_bit_o(link.a_bit), .rx_vld_o(link.a_vld), .rx_info_o(link.a_info),
      .k_i(k_i), .busy_i(busy_i), .cmd_i(cmd_i), .send_i(send_i), .kind_i(kind_i),
      .pf_i(pf_i), .send_rdy_o(send_rdy_o), .rcv_vld_o(rcv_vld_o),
      .rcv_rdy_i(rcv_rdy_i), .rcv_ctl_o(rcv_ctl_o), .vs_o(vs_o), .vr_o(vr_o),
      .ack_o(ack_o), .mode_o(mode_o), .peer_busy_o(peer_busy_o), .rej_o(rej_o),
      .status_req_o(status_req_o));
endmodule
`default_nettype wire

// >>> lsc_peer_end.sv
// Purpose: peer (DTE) end of the link
// Assumes: station core shared with the device end
// Notes:   no window limit at this end
`timescale 1ns/100ps
`default_nettype none
module lsc_peer_end (
   input  wire logic               clk_i,
   input  wire logic               rst_n_i,
   lsc_link_if.peer                link,
   input  wire logic               busy_i,
   input  wire logic               cmd_i,
   input  wire logic               send_i,
   input  wire lsc_pkg::lsc_kind_t kind_i,
   input  wire logic               pf_i,
   output logic                    send_rdy_o,
   output logic                    rcv_vld_o,
   input  wire logic               rcv_rdy_i,
   output logic [7:0]              rcv_ctl_o,
   output lsc_pkg::lsc_seq_t       vs_o,
   output lsc_pkg::lsc_seq_t       vr_o,
   output lsc_pkg::lsc_seq_t       ack_o,
   output lsc_pkg::lsc_mode_t      mode_o,
   output logic                    peer_busy_o,
   output logic                    rej_o,
   output logic                    status_req_o
);
   // dte core: window unused, so k is tied to the default
   lsc_station #(.IS_DCE(1'b0)) u_st (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .tx_bit_i(link.a_bit), .tx_vld_i(link.a_vld), .tx_info_i(link.a_info),
      .rx_bit_o(link.b_bit), .rx_vld_o(link.b_vld), .rx_info_o(link.b_info),
      .k_i(lsc_pkg::LSC_K_DEF), .busy_i(busy_i), .cmd_i(cmd_i), .send_i(send_i),
      .kind_i(kind_i), .pf_i(pf_i), .send_rdy_o(send_rdy_o), .rcv_vld_o(rcv_vld_o),
      .rcv_rdy_i(rcv_rdy_i), .rcv_ctl_o(rcv_ctl_o), .vs_o(vs_o), .vr_o(vr_o),
      .ack_o(ack_o), .mode_o(mode_o), .peer_busy_o(peer_busy_o), .rej_o(rej_o),
      .status_req_o(status_req_o));
endmodule
`default_nettype wire

// >>> lsc_link_props.sv
// Purpose: wire checks on the control-field link between the two ends
// Assumes: one clock; a frame is eight bit cycles, bit 1 first
// Notes:   octet rebuilt from the wire, so a coding slip shows here
`timescale 1ns/100ps
`default_nettype none
module lsc_link_props (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic a_bit,
   input  wire logic a_vld,
   input  wire logic a_info,
   input  wire logic b_bit,
   input  wire logic b_vld,
   input  wire logic b_info
);
   logic [2:0] a_cnt_q, a_cnt_d, b_cnt_q, b_cnt_d;
   logic [7:0] a_sh_q, a_sh_d, b_sh_q, b_sh_d;
   logic [7:0] a_oct, b_oct;

   // bit position and shifted octet; a gap in valid restarts the count
   always_comb begin
      a_cnt_d = a_vld ? a_cnt_q + 3'h1 : 3'h0;
      b_cnt_d = b_vld ? b_cnt_q + 3'h1 : 3'h0;
      a_sh_d  = a_vld ? {a_bit, a_sh_q[7:1]} : a_sh_q;
      b_sh_d  = b_vld ? {b_bit, b_sh_q[7:1]} : b_sh_q;
   end
   assign a_oct = {a_bit, a_sh_q[7:1]};
   assign b_oct = {b_bit, b_sh_q[7:1]};

   // helper registers only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         a_cnt_q <= 3'h0;
         b_cnt_q <= 3'h0;
         a_sh_q  <= 8'h00;
         b_sh_q  <= 8'h00;
      end else begin
         a_cnt_q <= a_cnt_d;
         b_cnt_q <= b_cnt_d;
         a_sh_q  <= a_sh_d;
         b_sh_q  <= b_sh_d;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence a_first; a_vld && a_cnt_q == 3'h0; endsequence
   sequence a_last;  a_vld && a_cnt_q == 3'h7; endsequence
   sequence b_first; b_vld && b_cnt_q == 3'h0; endsequence
   sequence b_last;  b_vld && b_cnt_q == 3'h7; endsequence

   chk_a_whole_frame: assert property (!a_vld |-> a_cnt_q == 3'h0)
      else $error("device frame not eight bits long");
   chk_b_whole_frame: assert property ($fell(b_vld) |-> b_cnt_q == 3'h0)
      else $error("peer frame not eight bits long");
   chk_a_first_bit: assert property (a_first |-> a_bit == !a_info)
      else $error("device first bit does not match frame kind");
   chk_b_first_bit: assert property (b_first |-> b_bit == !b_info)
      else $error("peer first bit does not match frame kind");
   chk_a_info_framed: assert property (a_info |-> a_vld)
      else $error("device info flag outside a frame");
   chk_a_info_steady: assert property (a_vld && a_cnt_q != 3'h0 |-> $stable(a_info))
      else $error("device info flag changed inside a frame");
   chk_a_super_code: assert property (a_last ##0 a_oct[1:0] == 2'b01 |->
      a_oct[3:2] != 2'b11)
      else $error("device sent a reserved supervisory code");
   chk_a_unnum_code: assert property (a_last ##0 a_oct[1:0] == 2'b11 |-> !a_info &&
      ((a_oct & 8'hEF) inside {8'h0F, 8'h2F, 8'h43, 8'h63, 8'h87}))
      else $error("device sent a bad unnumbered octet");
   chk_b_unnum_code: assert property (b_last ##0 b_oct[1:0] == 2'b11 |-> !b_info &&
      ((b_oct & 8'hEF) inside {8'h0F, 8'h2F, 8'h43, 8'h63, 8'h87}))
      else $error("peer sent a bad unnumbered octet");
endmodule
`default_nettype wire

// >>> lapb_link_sequence_control_tb.sv
// Purpose: drive both link ends against each other and judge state
// Assumes: shared kind, command and poll inputs; one end sends at a time
// Notes:   fixed waits cover one frame, or two where a UA answer follows
`timescale 1ns/100ps
`default_nettype none
module lapb_link_sequence_control_tb;
   logic clk_i, rst_n_i, d_send, p_send, s_cmd, s_pf, d_busy, p_busy, d_rrdy, p_rrdy;
   lsc_pkg::lsc_kind_t s_kind;
   lsc_pkg::lsc_seq_t  d_k, d_vs, d_vr, d_ack, p_vr;
   lsc_pkg::lsc_mode_t d_mode;
   logic d_rdy, p_rdy, d_rvld, p_rvld, d_pbusy, p_rej, d_stat;
   logic [7:0] d_ctl, p_ctl, d_last, p_last;
   int errors = 0, samples_checked = 0, d_rx_n = 0, d_st_n = 0;

   lsc_link_if link_inst ();
   lsc_dev_end lsc_dev_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_inst),
      .k_i(d_k), .busy_i(d_busy), .cmd_i(s_cmd), .send_i(d_send), .kind_i(s_kind),
      .pf_i(s_pf), .send_rdy_o(d_rdy), .rcv_vld_o(d_rvld), .rcv_rdy_i(d_rrdy),
      .rcv_ctl_o(d_ctl), .vs_o(d_vs), .vr_o(d_vr), .ack_o(d_ack), .mode_o(d_mode),
      .peer_busy_o(d_pbusy), .rej_o(), .status_req_o(d_stat));
   lsc_peer_end lsc_peer_end_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(link_inst),
      .busy_i(p_busy), .cmd_i(s_cmd), .send_i(p_send), .kind_i(s_kind), .pf_i(s_pf),
      .send_rdy_o(p_rdy), .rcv_vld_o(p_rvld), .rcv_rdy_i(p_rrdy), .rcv_ctl_o(p_ctl),
      .vs_o(), .vr_o(p_vr), .ack_o(), .mode_o(), .peer_busy_o(), .rej_o(p_rej),
      .status_req_o());
   lsc_link_props lsc_link_props_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .a_bit(link_inst.a_bit), .a_vld(link_inst.a_vld), .a_info(link_inst.a_info),
      .b_bit(link_inst.b_bit), .b_vld(link_inst.b_vld), .b_info(link_inst.b_info));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // collect received octets and status pulses off the handshakes
   always @(posedge clk_i) begin
      if (d_rvld && d_rrdy) begin
         d_last <= d_ctl;
         d_rx_n <= d_rx_n + 1;
      end
      if (p_rvld && p_rrdy) p_last <= p_ctl;
      if (d_stat === 1'b1) d_st_n <= d_st_n + 1;
   end

   task automatic print_verdict();
      if (errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // hold the request until the taking edge; readiness read mid-cycle
   task automatic send(input bit dv, input lsc_pkg::lsc_kind_t k, input logic c,
                       input logic p, input int gap);
      int n;
      n = 0;
      s_kind <= k;
      s_cmd <= c;
      s_pf <= p;
      if (dv) d_send <= 1'b1;
      else p_send <= 1'b1;
      @(negedge clk_i);
      while ((dv ? d_rdy : p_rdy) !== 1'b1) begin
         n++;
         if (n > 40) begin
            errors++;
            $display("Error at %0t: request never taken", $time);
            print_verdict();
         end
         @(negedge clk_i);
      end
      @(posedge clk_i);
      d_send <= 1'b0;
      p_send <= 1'b0;
      repeat (gap) @(posedge clk_i);
   endtask

   // present a request kind without sending, settled for reading
   task automatic pick(input lsc_pkg::lsc_kind_t k, input logic c);
      s_kind <= k;
      s_cmd <= c;
      @(negedge clk_i);
   endtask

   task automatic t_sabm();
      check(d_mode, lsc_pkg::LSC_M_DISC);
      send(1'b0, lsc_pkg::LSC_F_SABM, 1'b1, 1'b1, 24);
      check(d_last, 8'h3F);
      check(p_last, 8'h73);
      check(d_mode, lsc_pkg::LSC_M_ABM);
      check(d_vs, 8'h00);
      check(d_vr, 8'h00);
   endtask

   task automatic t_iframes();
      for (int i = 0; i < 3; i++) send(1'b1, lsc_pkg::LSC_F_I, 1'b1, 1'b0, 11);
      check(d_vs, 8'h03);
      check(p_vr, 8'h03);
      check(p_last, 8'h04);
   endtask

   task automatic t_reject();
      // peer busy: in-sequence frame 3 is not accepted, so REJ must rewind
      p_busy <= 1'b1;
      send(1'b1, lsc_pkg::LSC_F_I, 1'b1, 1'b0, 11);
      check(p_vr, 8'h03);
      check(d_vs, 8'h04);
      p_busy <= 1'b0;
      send(1'b0, lsc_pkg::LSC_F_REJ, 1'b0, 1'b0, 11);
      check(d_last, 8'h69);
      check(d_vs, 8'h03);
      check(d_ack, 8'h03);
      check(p_rej, 8'h01);
      send(1'b1, lsc_pkg::LSC_F_I, 1'b1, 1'b0, 11);
      check(p_rej, 8'h00);
      check(p_last, 8'h06);
   endtask

   task automatic t_busy();
      send(1'b0, lsc_pkg::LSC_F_RNR, 1'b1, 1'b1, 11);
      check(d_last, 8'h95);
      check(d_pbusy, 8'h01);
      check(8'(d_st_n), 8'h01);
      pick(lsc_pkg::LSC_F_I, 1'b1);
      check(d_rdy, 8'h00);
      @(posedge clk_i);
      send(1'b0, lsc_pkg::LSC_F_RR, 1'b1, 1'b0, 11);
      check(d_pbusy, 8'h00);
      check(d_ack, 8'h04);
   endtask

   task automatic t_window();
      d_k <= 3'h2;
      send(1'b1, lsc_pkg::LSC_F_I, 1'b1, 1'b0, 11);
      send(1'b1, lsc_pkg::LSC_F_I, 1'b1, 1'b0, 11);
      pick(lsc_pkg::LSC_F_I, 1'b1);
      check(d_rdy, 8'h00);
      check(d_vs, 8'h06);
      @(posedge clk_i);
   endtask

   task automatic t_sarm();
      send(1'b0, lsc_pkg::LSC_F_SARM, 1'b1, 1'b1, 24);
      check(d_last, 8'h1F);
      check(d_mode, lsc_pkg::LSC_M_ARM);
      check(d_vs, 8'h06);
      pick(lsc_pkg::LSC_F_RR, 1'b1);
      check(d_rdy, 8'h00);
      @(posedge clk_i);
      pick(lsc_pkg::LSC_F_RR, 1'b0);
      check(d_rdy, 8'h01);
      @(posedge clk_i);
      // supervisory response with final bit still allowed in response mode
      send(1'b1, lsc_pkg::LSC_F_RR, 1'b0, 1'b1, 11);
      check(p_last, 8'h11);
   endtask

   // two-entry receive buffer: third octet is dropped while stalled
   task automatic t_stall();
      int n0;
      n0 = d_rx_n;
      d_rrdy <= 1'b0;
      for (int i = 0; i < 3; i++) send(1'b0, lsc_pkg::LSC_F_RR, 1'b0, 1'b0, 11);
      check(d_rvld, 8'h01);
      d_rrdy <= 1'b1;
      repeat (6) @(posedge clk_i);
      check(8'(d_rx_n - n0), 8'h02);
      check(d_last, 8'hC1);
   endtask

   initial begin
      rst_n_i = 1'b0;
      d_send = 1'b0;
      p_send = 1'b0;
      s_cmd = 1'b0;
      s_pf = 1'b0;
      s_kind = lsc_pkg::LSC_F_RR;
      d_k = 3'h7;
      d_busy = 1'b0;
      p_busy = 1'b0;
      d_rrdy = 1'b1;
      p_rrdy = 1'b1;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_sabm();
      t_iframes();
      t_reject();
      t_busy();
      t_window();
      t_sarm();
      t_stall();
      print_verdict();
   end
endmodule
`default_nettype wire
